// ### verilog/spp_pkg.sv
// constants of the six-pin port block
// Functional notes
// - pin-level read shows pins; latch read shows latch
// - direction bit one means output, zero input
// - output drives latch value, never pulled up
// - input with latch one gets pull-up
// - pull-up kill bit disables every pull-up
// - any reset tri-states all pins asynchronously
// - pin five input-only or open-drain low
// - fuse unprogrammed makes pin five external reset
// - pins four, three carry oscillator when used
// - counter clock follows pin two even as output
// - pin one feeds interrupt zero, comparator minus
// - all pins feed change detector; pin zero comparator plus
// - programming mode: pin two clock, one in, zero out
// - power-down cuts digital inputs of comparator pins
package spp_pkg;
  localparam int NPINS = 6;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PIN_LEVEL = 8'h16;
  localparam logic [7:0] IDX_DIRECTION = 8'h17;
  localparam logic [7:0] IDX_OUT_LATCH = 8'h18;
  localparam logic [7:0] IDX_MCU_CTRL = 8'h20;
  localparam logic [7:0] IDX_PIN_CFG = 8'h21;
  localparam logic [7:0] ADDR_PIN_LEVEL = {IDX_PIN_LEVEL[5:0], 2'b00};
  localparam logic [7:0] ADDR_DIRECTION = {IDX_DIRECTION[5:0], 2'b00};
  localparam logic [7:0] ADDR_OUT_LATCH = {IDX_OUT_LATCH[5:0], 2'b00};
  localparam logic [7:0] ADDR_MCU_CTRL = {IDX_MCU_CTRL[5:0], 2'b00};
  localparam logic [7:0] ADDR_PIN_CFG = {IDX_PIN_CFG[5:0], 2'b00};
  // field positions
  localparam int CTRL_PULLUP_KILL = 0;
  localparam int CFG_OSC_IN_USE = 0;
  localparam int CFG_OSC_OUT_USE = 1;
  localparam int CFG_CNT_EXT = 2;
  localparam int PIN_CMP_POS = 0;
  localparam int PIN_CMP_NEG = 1;
  localparam int PIN_CNT_CLK = 2;
  localparam int PIN_OSC_IN = 3;
  localparam int PIN_OSC_OUT = 4;
  localparam int PIN_RESET = 5;
  // masks and reset values
  localparam logic [5:0] MASK_SMALL = 6'h1F;
  localparam logic [5:0] MASK_FULL = 6'h3F;
  localparam logic [5:0] RST_PORT = 6'h00;
  localparam logic [2:0] RST_CFG = 3'h0;
endpackage

// ### verilog/spp_pin_cell.sv
// pad control for one port pin
`timescale 1ns/1ns
`default_nettype none
module spp_pin_cell #(
  parameter bit OPEN_DRAIN = 1'b0,
  parameter bit INPUT_ONLY = 1'b0
) (
  input wire logic rst,
  input wire logic dirBit,
  input wire logic latchBit,
  input wire logic pullKill,
  input wire logic altEn,
  input wire logic altOut,
  input wire logic altOe,
  input wire logic cutIn,
  input wire logic padIn,
  output logic padOut,
  output logic padOe,
  output logic padPullup,
  output logic pinLevel
);
  logic pullWanted;

  assign pullWanted = ~dirBit & latchBit & ~pullKill;
  // digital buffer cut forces a quiet zero, no floating level
  assign pinLevel = cutIn ? 1'b0 : padIn;

  always_comb begin
    padOut = 1'b0;
    padOe = 1'b0;
    padPullup = 1'b0;
    if (rst) begin
      padOe = 1'b0;
    end else if (altEn) begin
      padOut = altOut;
      padOe = altOe;
    end else if (INPUT_ONLY) begin
      padPullup = pullWanted;
    end else if (OPEN_DRAIN) begin
      padOe = dirBit & ~latchBit;
      padPullup = pullWanted;
    end else begin
      padOut = latchBit;
      padOe = dirBit;
      padPullup = pullWanted;
    end
  end
endmodule
`default_nettype wire

// ### verilog/spp_port_io.sv
// six-pin general I/O port with APB register access
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
module spp_port_io
  import spp_pkg::*;
#(
  parameter bit HAS_EEPROM = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NPINS-1:0] padIn,
  output logic [NPINS-1:0] padOut,
  output logic [NPINS-1:0] padOe,
  output logic [NPINS-1:0] padPullup,
  input wire logic resetFuseProgrammed,
  input wire logic progMode,
  input wire logic progDataOut,
  input wire logic oscDrive,
  input wire logic powerDown,
  output logic extResetReq,
  output logic oscInClk,
  output logic cntClkIn,
  output logic extIrq0In,
  output logic pinChangeEvt,
  output logic progSck,
  output logic progSdi
);
  localparam logic [5:0] DIR_MASK = HAS_EEPROM ? MASK_FULL : MASK_SMALL;

  logic [5:0] dir_reg, dir_next;
  logic [5:0] latch_reg, latch_next;
  logic kill_reg, kill_next;
  logic [2:0] cfg_reg, cfg_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [5:0] prevPin_reg, prevPin_next;
  logic chg_reg, chg_next;
  logic primed_reg, primed_next;
  logic [5:0] pinLevel;
  logic [5:0] altEn, altOut, altOe, cutIn;
  logic setup, access, hit, wrAcc;
  logic progOn, killEff;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign hit = (paddr == ADDR_PIN_LEVEL) || (paddr == ADDR_DIRECTION) ||
    (paddr == ADDR_OUT_LATCH) || (paddr == ADDR_MCU_CTRL) ||
    (paddr == ADDR_PIN_CFG);
  assign pready = access;
  assign pslverr = access & ~hit;
  assign wrAcc = access & pwrite & hit;
  assign prdata = rdata_reg;

  // programming and pull-up kill exist only on the larger variant
  assign progOn = HAS_EEPROM & progMode;
  assign killEff = HAS_EEPROM & kill_reg;

  // register file
  always_comb begin
    dir_next = dir_reg;
    latch_next = latch_reg;
    kill_next = kill_reg;
    cfg_next = cfg_reg;
    rdata_next = rdata_reg;
    if (wrAcc) begin
      case (paddr)
        ADDR_DIRECTION: dir_next = pwdata[5:0] & DIR_MASK;
        ADDR_OUT_LATCH: latch_next = pwdata[5:0];
        ADDR_MCU_CTRL: kill_next = pwdata[CTRL_PULLUP_KILL];
        ADDR_PIN_CFG: cfg_next = pwdata[2:0];
        default: ; // pin-level address holds nothing
      endcase
    end
    // read data captured in setup so the answer comes from a flop
    if (setup && !pwrite) begin
      rdata_next = '0;
      case (paddr)
        ADDR_PIN_LEVEL: rdata_next[5:0] = pinLevel;
        ADDR_DIRECTION: rdata_next[5:0] = dir_reg;
        ADDR_OUT_LATCH: rdata_next[5:0] = latch_reg;
        ADDR_MCU_CTRL: rdata_next[CTRL_PULLUP_KILL] = kill_reg;
        ADDR_PIN_CFG: rdata_next[2:0] = cfg_reg;
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dir_reg <= RST_PORT;
      latch_reg <= RST_PORT;
      kill_reg <= 1'b0;
      cfg_reg <= RST_CFG;
      rdata_reg <= '0;
    end else begin
      dir_reg <= dir_next;
      latch_reg <= latch_next;
      kill_reg <= kill_next;
      cfg_reg <= cfg_next;
      rdata_reg <= rdata_next;
    end
  end

  // alternate functions override the plain port settings
  always_comb begin
    altEn = '0;
    altOut = '0;
    altOe = '0;
    cutIn = '0;
    altEn[PIN_RESET] = ~resetFuseProgrammed;
    altEn[PIN_OSC_OUT] = cfg_reg[CFG_OSC_OUT_USE];
    altOut[PIN_OSC_OUT] = oscDrive;
    altOe[PIN_OSC_OUT] = 1'b1;
    altEn[PIN_OSC_IN] = cfg_reg[CFG_OSC_IN_USE];
    altEn[PIN_CNT_CLK] = progOn;
    altEn[PIN_CMP_NEG] = progOn;
    altEn[PIN_CMP_POS] = progOn;
    altOut[PIN_CMP_POS] = progDataOut;
    altOe[PIN_CMP_POS] = progOn;
    cutIn[PIN_CMP_POS] = powerDown;
    cutIn[PIN_CMP_NEG] = powerDown;
  end

  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : gPin
      spp_pin_cell #(
        .OPEN_DRAIN((g == PIN_RESET) && HAS_EEPROM),
        .INPUT_ONLY((g == PIN_RESET) && !HAS_EEPROM)
      ) uCell (
        .rst(rst),
        .dirBit(dir_reg[g]),
        .latchBit(latch_reg[g]),
        .pullKill(killEff),
        .altEn(altEn[g]),
        .altOut(altOut[g]),
        .altOe(altOe[g]),
        .cutIn(cutIn[g]),
        .padIn(padIn[g]),
        .padOut(padOut[g]),
        .padOe(padOe[g]),
        .padPullup(padPullup[g]),
        .pinLevel(pinLevel[g])
      );
    end
  endgenerate

  // peripheral feeds read the pin whatever its direction
  // reset pin is active low on the board
  assign extResetReq = ~resetFuseProgrammed & ~padIn[PIN_RESET];
  assign oscInClk = cfg_reg[CFG_OSC_IN_USE] & padIn[PIN_OSC_IN];
  assign cntClkIn = cfg_reg[CFG_CNT_EXT] & pinLevel[PIN_CNT_CLK];
  assign extIrq0In = pinLevel[PIN_CMP_NEG];
  assign progSck = progOn & padIn[PIN_CNT_CLK];
  assign progSdi = progOn & padIn[PIN_CMP_NEG];
  assign pinChangeEvt = chg_reg;

  // pin change detector over all six pins
  always_comb begin
    prevPin_next = pinLevel;
    primed_next = 1'b1;
    // no compare until a real sample is held: a pulled-up pin
    // would otherwise raise a false event right after reset
    chg_next = primed_reg & |(pinLevel ^ prevPin_reg);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prevPin_reg <= RST_PORT;
      primed_reg <= 1'b0;
      chg_reg <= 1'b0;
    end else begin
      prevPin_reg <= prevPin_next;
      primed_reg <= primed_next;
      chg_reg <= chg_next;
    end
  end

  property p_pin_read;
    @(posedge clk_sys) disable iff (rst)
      (setup && !pwrite && paddr == ADDR_PIN_LEVEL)
        |=> prdata[5:0] == $past(pinLevel);
  endproperty
  a_pin_read: assert property (p_pin_read)
    else $error("pin-level read wrong");

  property p_latch_read;
    @(posedge clk_sys) disable iff (rst)
      (setup && !pwrite && paddr == ADDR_OUT_LATCH)
        |=> prdata[5:0] == $past(latch_reg);
  endproperty
  a_latch_read: assert property (p_latch_read)
    else $error("latch read wrong");

  property p_dir_out;
    @(posedge clk_sys) disable iff (rst)
      !progOn |-> padOe[PIN_CNT_CLK] == dir_reg[PIN_CNT_CLK];
  endproperty
  a_dir_out: assert property (p_dir_out)
    else $error("direction not applied");

  property p_drive;
    @(posedge clk_sys) disable iff (rst)
      (wrAcc && paddr == ADDR_OUT_LATCH && !progOn && dir_reg[1])
        |=> padOut[1] == $past(pwdata[1]) && !padPullup[1];
  endproperty
  a_drive: assert property (p_drive)
    else $error("output not driving latch");

  property p_pullup;
    @(posedge clk_sys) disable iff (rst)
      (!progOn && !killEff && !dir_reg[1] && latch_reg[1])
        |-> padPullup[1] && !padOe[1];
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up missing");

  property p_kill;
    @(posedge clk_sys) disable iff (rst)
      killEff |-> padPullup == '0;
  endproperty
  a_kill: assert property (p_kill)
    else $error("pull-up while killed");

  property p_reset_tristate;
    @(posedge clk_sys) rst |-> padOe == '0 && padPullup == '0;
  endproperty
  a_reset_tristate: assert property (p_reset_tristate)
    else $error("pin driven in reset");

  property p_pin5_low_only;
    @(posedge clk_sys) disable iff (rst)
      padOe[PIN_RESET] |-> HAS_EEPROM && !padOut[PIN_RESET];
  endproperty
  a_pin5_low_only: assert property (p_pin5_low_only)
    else $error("pin five drove high");

  property p_reset_pin;
    @(posedge clk_sys) disable iff (rst)
      !resetFuseProgrammed |->
        !padOe[PIN_RESET] && extResetReq == !padIn[PIN_RESET];
  endproperty
  a_reset_pin: assert property (p_reset_pin)
    else $error("reset pin misused");

  property p_osc_out;
    @(posedge clk_sys) disable iff (rst)
      cfg_reg[CFG_OSC_OUT_USE] |->
        padOe[PIN_OSC_OUT] && padOut[PIN_OSC_OUT] == oscDrive;
  endproperty
  a_osc_out: assert property (p_osc_out)
    else $error("oscillator pin wrong");

  property p_cnt_clk;
    @(posedge clk_sys) disable iff (rst)
      (cfg_reg[CFG_CNT_EXT] && !powerDown)
        |-> cntClkIn == padIn[PIN_CNT_CLK];
  endproperty
  a_cnt_clk: assert property (p_cnt_clk)
    else $error("counter clock lost");

  property p_irq0;
    @(posedge clk_sys) disable iff (rst)
      !powerDown |-> extIrq0In == padIn[PIN_CMP_NEG];
  endproperty
  a_irq0: assert property (p_irq0)
    else $error("interrupt zero feed wrong");

  property p_change;
    @(posedge clk_sys) disable iff (rst)
      ($changed(padIn[5:2]) && !$past(rst)) |=> pinChangeEvt;
  endproperty
  a_change: assert property (p_change)
    else $error("pin change missed");

  property p_prog_out;
    @(posedge clk_sys) disable iff (rst)
      progOn |-> padOe[PIN_CMP_POS] && !padOe[PIN_CNT_CLK]
        && padOut[PIN_CMP_POS] == progDataOut;
  endproperty
  a_prog_out: assert property (p_prog_out)
    else $error("programming pins wrong");

  property p_cut;
    @(posedge clk_sys) disable iff (rst)
      powerDown |-> pinLevel[1:0] == 2'b00 && !extIrq0In;
  endproperty
  a_cut: assert property (p_cut)
    else $error("comparator input not cut");

  property p_upper_zero;
    @(posedge clk_sys) disable iff (rst)
      (setup && !pwrite && paddr == ADDR_PIN_LEVEL)
        |=> prdata[DATA_W-1:6] == '0;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper pin bits not zero");

  c_write_dir: cover property (@(posedge clk_sys) disable iff (rst)
    wrAcc && paddr == ADDR_DIRECTION);
  c_pin_change: cover property (@(posedge clk_sys) disable iff (rst)
    pinChangeEvt);
  c_prog: cover property (@(posedge clk_sys) disable iff (rst)
    progOn && padOe[PIN_CMP_POS]);
  c_bad_addr: cover property (@(posedge clk_sys) disable iff (rst)
    pslverr);
endmodule
`default_nettype wire

// ### verification/spp_board_model.sv
// board side of the six port pins: pad, external driver, pull-up, float
`timescale 1ns/1ns
`default_nettype none
module spp_board_model (
  input wire logic clk_sys,
  input wire logic [5:0] padOut,
  input wire logic [5:0] padOe,
  input wire logic [5:0] padPullup,
  input wire logic [5:0] extDrv,
  input wire logic [5:0] extEn,
  output logic [5:0] padIn
);
  logic [5:0] floatPat = 6'h15;
  // a floating pin toggles so it never passes for a steady level
  always @(posedge clk_sys) floatPat <= ~floatPat;
  assign padIn = padOe & padOut | ~padOe & (extEn & extDrv |
    ~extEn & (padPullup | floatPat));
endmodule
`default_nettype wire

// ### verification/six_pin_port_io_tb_top.sv
// bench for the six-pin port: APB tasks, read scoreboard, pin checks
`timescale 1ns/1ns
`default_nettype none
module six_pin_port_io_tb_top;
  import spp_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, extResetReq, oscInClk, cntClkIn, extIrq0In;
  logic pinChangeEvt, progSck, progSdi, fuse = 1'b1, progMode = 1'b0;
  logic progDataOut = 1'b0, oscDrive = 1'b0, powerDown = 1'b0;
  logic [5:0] padIn, padOut, padOe, padPullup, d, l, x;
  logic [5:0] extDrv = 6'h00, extEn = 6'h3F;
  logic [32:0] expQ[$];
  int failCount = 0, checked = 0, cyc = 0;

  always #25 clk_sys = ~clk_sys;

  spp_port_io #(.HAS_EEPROM(1'b1)) dut_u (.clk_sys(clk_sys), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .padIn(padIn), .padOut(padOut), .padOe(padOe), .padPullup(padPullup),
    .resetFuseProgrammed(fuse), .progMode(progMode),
    .progDataOut(progDataOut), .oscDrive(oscDrive),
    .powerDown(powerDown), .extResetReq(extResetReq),
    .oscInClk(oscInClk), .cntClkIn(cntClkIn), .extIrq0In(extIrq0In),
    .pinChangeEvt(pinChangeEvt), .progSck(progSck), .progSdi(progSdi));
  spp_board_model board_u (.clk_sys(clk_sys), .padOut(padOut),
    .padOe(padOe), .padPullup(padPullup), .extDrv(extDrv),
    .extEn(extEn), .padIn(padIn));

  task automatic end_of_test();
    if (expQ.size() != 0) failCount++;
    if (failCount == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic cmpRd(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: read %h not %h", $time, got, exp);
    end
  endtask

  task automatic cmp6(input logic [5:0] got, input logic [5:0] exp);
    checked++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: pins %h not %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [5:0] v);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {26'h0, v};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expQ.push_back(e);
    apb(1'b0, a, 6'h00);
  endtask

  // read scoreboard: oldest expectation against each completed read
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0)
      cmpRd({pslverr, prdata}, expQ.pop_front());
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      failCount++;
      $display("wrong value at %0t: timeout", $time);
      end_of_test();
    end
  end

  initial begin
    void'($urandom(32'h8EEA));
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ADDR_DIRECTION, 33'h0);
    rd(8'hFC, {1'b1, 32'h0});
    for (int i = 0; i < 8; i++) begin
      d = 6'($urandom) & 6'h1F;
      l = 6'($urandom);
      x = 6'($urandom);
      @(posedge clk_sys);
      extEn <= ~d;
      extDrv <= x;
      apb(1'b1, ADDR_DIRECTION, d);
      apb(1'b1, ADDR_OUT_LATCH, l);
      #1 cmp6(padOe, d);
      cmp6(padOut & d, l & d);
      cmp6(padPullup, ~d & l);
      apb(1'b1, ADDR_PIN_LEVEL, ~l);
      rd(ADDR_OUT_LATCH, {27'h0, l});
      rd(ADDR_PIN_LEVEL, {27'h0, d & l | ~d & x});
      rd(ADDR_DIRECTION, {27'h0, d});
    end
    apb(1'b1, ADDR_DIRECTION, 6'h00);
    // settle every pin on a driven level before the first toggle
    @(posedge clk_sys);
    extEn <= 6'h3F;
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_sys);
      extDrv[k] <= ~extDrv[k];
      @(posedge clk_sys);
      #1 cmp6({5'h0, pinChangeEvt}, 6'h01);
      @(posedge clk_sys);
      #1 cmp6({5'h0, pinChangeEvt}, 6'h00);
    end
    @(posedge clk_sys);
    extEn <= 6'h00;
    apb(1'b1, ADDR_OUT_LATCH, 6'h3F);
    #1 cmp6(padPullup, 6'h3F);
    apb(1'b1, ADDR_MCU_CTRL, 6'h01);
    #1 cmp6(padPullup, 6'h00);
    rd(ADDR_MCU_CTRL, 33'h1);
    apb(1'b1, ADDR_MCU_CTRL, 6'h00);
    apb(1'b1, ADDR_OUT_LATCH, 6'h00);
    apb(1'b1, ADDR_DIRECTION, 6'h20);
    #1 cmp6({padOe[5], padOut[5], 4'h0}, 6'h20);
    apb(1'b1, ADDR_OUT_LATCH, 6'h20);
    #1 cmp6({padOe[5], padPullup[5], 4'h0}, 6'h00);
    @(posedge clk_sys);
    fuse <= 1'b0;
    extEn <= 6'h20;
    extDrv <= 6'h00;
    apb(1'b1, ADDR_OUT_LATCH, 6'h00);
    #1 cmp6({padOe[5], extResetReq, 4'h0}, 6'h10);
    @(posedge clk_sys);
    extDrv <= 6'h20;
    #1 cmp6({padOe[5], extResetReq, 4'h0}, 6'h00);
    @(posedge clk_sys);
    fuse <= 1'b1;
    extEn <= 6'h29;
    extDrv <= 6'h3F;
    oscDrive <= 1'b1;
    apb(1'b1, ADDR_DIRECTION, 6'h06);
    apb(1'b1, ADDR_OUT_LATCH, 6'h06);
    apb(1'b1, ADDR_PIN_CFG, 6'h07);
    #1 cmp6({3'h0, oscInClk, padOe[4], padOut[4]}, 6'h07);
    cmp6({4'h0, cntClkIn, extIrq0In}, 6'h03);
    rd(ADDR_PIN_CFG, 33'h07);
    apb(1'b1, ADDR_OUT_LATCH, 6'h00);
    #1 cmp6({4'h0, cntClkIn, extIrq0In}, 6'h00);
    @(posedge clk_sys);
    powerDown <= 1'b1;
    apb(1'b1, ADDR_OUT_LATCH, 6'h06);
    #1 cmp6({5'h0, extIrq0In}, 6'h00);
    rd(ADDR_PIN_LEVEL, 33'h3C);
    @(posedge clk_sys);
    powerDown <= 1'b0;
    progMode <= 1'b1;
    progDataOut <= 1'b1;
    extEn <= 6'h3E;
    extDrv <= 6'h04;
    apb(1'b1, ADDR_DIRECTION, 6'h00);
    #1 cmp6({progSck, progSdi, padOe[0], padOut[0], 2'h0}, 6'h2C);
    @(posedge clk_sys);
    extDrv <= 6'h02;
    #1 cmp6({progSck, progSdi, padOe[0], padOut[0], 2'h0}, 6'h1C);
    apb(1'b1, ADDR_DIRECTION, 6'h1F);
    @(posedge clk_sys);
    rst <= 1'b1;
    progMode <= 1'b0;
    #1 cmp6(padOe | padPullup, 6'h00);
    @(posedge clk_sys);
    rst <= 1'b0;
    rd(ADDR_OUT_LATCH, 33'h0);
    @(posedge clk_sys);
    end_of_test();
  end
endmodule
`default_nettype wire
